// *** common/mux_pkg.sv ***
// Constants shared by the serial multiplexer channel service logic
package mux_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses (APB, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ICW = 8'h00;
  localparam logic [7:0] ADDR_OCW = 8'h04;
  localparam logic [7:0] ADDR_IBP = 8'h08;
  localparam logic [7:0] ADDR_LIB = 8'h0c;
  localparam logic [7:0] ADDR_OBP = 8'h10;
  localparam logic [7:0] ADDR_LOB = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_STATC = 8'h1c;
  localparam logic [7:0] ADDR_CMD = 8'h20;
  localparam logic [7:0] ADDR_TERM = 8'h24;
  // Buffer memory window: 0x40..0x7C, 16 words
  localparam logic [1:0] MEM_PAGE = 2'b01;

  // ---------------------------------------------------------------
  // Control word fields (word bit 0 of the 16-bit word is the MSB)
  // ---------------------------------------------------------------
  localparam int W_DONE = 15;
  localparam int ICW_AUTO = 14;
  localparam int ICW_ECHO = 13;
  localparam int ICW_MODE = 12;
  localparam int ICW_ERR_HI = 11;
  localparam int ICW_ERR_LO = 10;
  localparam int ICW_ECHO_FAIL = 9;
  localparam int OCW_X = 11;
  localparam int OCW_SPECIAL = 12;
  localparam int OCW_CHANGED = 8;
  localparam logic [1:0] ERR_PARITY = 2'b01;
  localparam logic [1:0] ERR_LATE = 2'b10;
  localparam logic [1:0] ERR_BREAK = 2'b11;
  localparam logic [1:0] OUT_AUTO = 2'b01;
  localparam logic [1:0] OUT_PORTCTL = 2'b10;
  localparam logic [1:0] OUT_SINGLE = 2'b11;
  localparam logic [7:0] MSB_FORCE = 8'h80;

  // ---------------------------------------------------------------
  // Commands, terminal strobes and port control defaults
  // ---------------------------------------------------------------
  localparam int CMD_START = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CMD_PULSE_P = 2;
  localparam int CMD_WRITE_B = 3;
  localparam int TW_S_OUT = 8;
  localparam int TW_C_OUT = 9;
  localparam int TW_S_IN = 10;
  localparam int TW_C_IN = 11;
  localparam logic [6:0] PORT_ID = 7'h00;
  // 8 data bits, parity inhibited, 2 stop bits; baud in bits 3:0
  localparam logic [11:0] CFG_8N2 = 12'h01e0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int RTC_PERIOD_US = 10000;
  localparam int RTC_CYCLES = RTC_PERIOD_US * CLK_MHZ;
endpackage

// *** rtl/mux_channel.sv ***
// Port service logic of a data-channel serial multiplexer
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps

// What this block does
// (RL1) Single input stores char, optional forced MSB
// (RL2) Single output sends char, done on pickup
// (RL3) Byte address: word shifted, bit0 picks byte
// (RL4) Auto input fills buffer until pointer hits last
// (RL5) Input modes select echo and special detection
// (RL6) Input errors coded in bits 4,5, echo fail 6
// (RL7) Special input char stored in low byte
// (RL8) Input past full buffer still stored, interrupts
// (RL9) Auto output runs until pointer hits last
// (RL10) Output mode words; wrong status digit interrupts
// (RL11) Status change during output flags bit 7
// (RL12) Special output char stored, pointer stays on it
// (RL13) Software waits output-done before new control
// (RL14) Clearing status read keeps done if pending
// (RL15) Status word layout: clock, scan, in, out, port
// (RL16) Handler reads status until low bits clear
// (RL17) Reset gives terminal mode, 8N2, switch baud
// (RL18) Terminal input done, busy and reader control
// (RL19) Terminal output busy, done and interrupt
// (RL20) Start leaves terminal mode, clears its flags
// (RL21) Clear pulse returns terminal mode, keeps params
// (RL22) P pulse runs the clock alone in terminal mode
// (RL23) Start sets busy until reset, clear or B write
// (RL24) Pointer increments before each byte transfer
module mux_channel
  import mux_pkg::*;
#(
  parameter int RTC_TICKS = RTC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_err,
  input wire logic rx_break,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic dev_status,
  input wire logic [3:0] baud_sel,
  output logic [11:0] port_cfg,
  output logic reader_ctrl,
  output logic term_mode,
  output logic intr_req
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] input_control_word, output_control_word, input_byte_pointer, last_input_byte, output_byte_pointer, last_output_byte;
    logic [15:0][15:0] mem;
    logic [11:0] cfg;
    logic cfg_done, mux_mode, mux_busy, mux_done, rtc_en;
    logic rtc_pend, scan_pend, in_pend, out_pend;
    logic [16:0] rtc_cnt;
    logic tti_busy, tti_done, tto_busy, tto_done;
    logic [7:0] tti_char, tto_char;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_term, rxs_valid;
    logic [7:0] rxs_data;
    logic rxs_perr, rxs_brk, rxs_late, dev_prev;
  } state_t;
  state_t s_q;
  state_t s_d;
  logic wr, rd, drain, ev_in, ev_out, in_ev, out_ev, mismatch;
  logic [15:0] nxt_i, nxt_o;
  logic [7:0] byte_o;
  logic [3:0] stat_hot;
  logic [15:0] stat_w;

  // Control characters count as special in both directions
  function automatic logic is_special(input logic [7:0] c);
    is_special = (c[6:5] == 2'b00);
  endfunction

  // ---------------------------------------------------------------
  // Status word: highest pending source is reported first
  // ---------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign stat_hot = s_q.rtc_pend ? 4'b1000 :
                    s_q.scan_pend ? 4'b0100 :
                    s_q.in_pend ? 4'b0010 :
                    s_q.out_pend ? 4'b0001 : 4'b0000;
  assign stat_w = {stat_hot, PORT_ID, 5'b00000}; // RL15

  // Buffer write port is shared, so an APB write stalls the rx stage
  assign drain = s_q.rxs_valid & ~wr;
  assign mismatch = s_q.output_control_word[OCW_X] != dev_status;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev_in = 1'b0;
    ev_out = 1'b0;
    in_ev = 1'b0;
    out_ev = 1'b0;
    nxt_i = s_q.input_byte_pointer + 16'h0001; // RL24
    nxt_o = s_q.output_byte_pointer + 16'h0001; // RL24
    byte_o = nxt_o[0] ? s_q.mem[nxt_o[4:1]][7:0] : s_q.mem[nxt_o[4:1]][15:8]; // RL3
    // Baud switch captured once after reset release
    if (!s_q.cfg_done) begin
      s_d.cfg = CFG_8N2 | {8'h00, baud_sel}; // RL17
      s_d.cfg_done = 1'b1;
    end
    // Register writes and commands
    if (wr) begin
      if (paddr[7:6] == MEM_PAGE) begin
        s_d.mem[paddr[5:2]] = pwdata[15:0];
      end else begin
        case (paddr)
          ADDR_ICW: s_d.input_control_word = pwdata[15:0];
          ADDR_OCW: s_d.output_control_word = pwdata[15:0];
          ADDR_IBP: s_d.input_byte_pointer = pwdata[15:0];
          ADDR_LIB: s_d.last_input_byte = pwdata[15:0];
          ADDR_OBP: s_d.output_byte_pointer = pwdata[15:0];
          ADDR_LOB: s_d.last_output_byte = pwdata[15:0];
          ADDR_CMD: begin
            if (pwdata[CMD_START]) begin
              s_d.mux_mode = 1'b1; // RL20
              s_d.mux_busy = 1'b1; // RL23
              s_d.rtc_en = 1'b0;
              s_d.tti_busy = 1'b0; // RL20
              s_d.tti_done = 1'b0;
              s_d.tto_busy = 1'b0;
              s_d.tto_done = 1'b0;
            end
            if (pwdata[CMD_CLEAR]) begin
              // Port parameters are kept on purpose
              s_d.mux_mode = 1'b0; // RL21
              s_d.mux_busy = 1'b0; // RL23
              s_d.mux_done = 1'b0;
              s_d.rtc_en = 1'b0;
              s_d.rtc_pend = 1'b0;
              s_d.scan_pend = 1'b0;
              s_d.in_pend = 1'b0;
              s_d.out_pend = 1'b0;
            end
            if (pwdata[CMD_PULSE_P] && !s_q.mux_mode) begin
              s_d.rtc_en = 1'b1; // RL22
              s_d.mux_busy = 1'b1; // RL22
            end
            if (pwdata[CMD_WRITE_B]) begin
              s_d.mux_busy = 1'b0; // RL23
            end
          end
          ADDR_TERM: begin
            s_d.tto_char = pwdata[7:0];
            if (pwdata[TW_S_OUT] && !s_q.mux_mode) begin
              // A strobe while a char is still held is dropped
              if (!s_d.tx_valid) begin
                s_d.tx_valid = 1'b1;
                s_d.tx_data = pwdata[7:0];
                s_d.tx_term = 1'b1;
              end
              s_d.tto_busy = 1'b1; // RL19
              s_d.tto_done = 1'b0; // RL19
            end
            if (pwdata[TW_C_OUT]) begin
              s_d.tto_busy = 1'b0; // RL19
              s_d.tto_done = 1'b0;
            end
            if (pwdata[TW_S_IN]) begin
              s_d.tti_busy = 1'b1; // RL18
              s_d.tti_done = 1'b0; // RL18
            end
            if (pwdata[TW_C_IN]) begin
              s_d.tti_busy = 1'b0; // RL18
              s_d.tti_done = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    // Port drains the holding register; completion beats a C strobe
    if (s_q.tx_valid && tx_ready) begin
      s_d.tx_valid = 1'b0;
      s_d.tx_term = 1'b0;
      if (s_q.tx_term && !s_d.mux_mode && s_q.tto_busy) begin
        s_d.tto_busy = 1'b0; // RL19
        s_d.tto_done = 1'b1; // RL19
      end
    end
    // Status reads; the clearing read pops one source
    if (rd && paddr == ADDR_STATC) begin
      s_d.rtc_pend = s_d.rtc_pend & ~stat_hot[3];
      s_d.scan_pend = s_d.scan_pend & ~stat_hot[2];
      s_d.in_pend = s_d.in_pend & ~stat_hot[1];
      s_d.out_pend = s_d.out_pend & ~stat_hot[0];
      s_d.mux_done = s_d.rtc_pend | s_d.scan_pend | s_d.in_pend | s_d.out_pend; // RL14
    end
    if (rd && paddr == ADDR_STAT) begin
      s_d.rtc_pend = 1'b0;
    end
    // Receive stage; a char arriving while stalled is late
    if (rx_valid && (!s_q.rxs_valid || drain)) begin
      s_d.rxs_valid = 1'b1;
      s_d.rxs_data = rx_data;
      s_d.rxs_perr = rx_parity_err;
      s_d.rxs_brk = rx_break;
      s_d.rxs_late = 1'b0;
    end else if (rx_valid) begin
      s_d.rxs_late = 1'b1;
    end else if (drain) begin
      s_d.rxs_valid = 1'b0;
    end
    // Input service
    if (drain) begin
      if (!s_q.mux_mode) begin
        s_d.tti_char = s_q.rxs_data;
        s_d.tti_done = 1'b1; // RL18
        s_d.tti_busy = 1'b0; // RL18
      end else if (s_q.mux_busy && !s_q.rtc_en && !s_q.input_control_word[W_DONE]) begin
        if (s_q.input_control_word[ICW_AUTO]) begin
          // Only the addressed byte changes; its partner survives
          if (nxt_i[0]) begin
            s_d.mem[nxt_i[4:1]][7:0] = s_q.rxs_data; // RL4
          end else begin
            s_d.mem[nxt_i[4:1]][15:8] = s_q.rxs_data; // RL4
          end
          s_d.input_byte_pointer = nxt_i; // RL24
          in_ev = (s_q.input_byte_pointer == s_q.last_input_byte) | (nxt_i == s_q.last_input_byte); // RL4 RL8
          if (s_q.rxs_brk) begin
            s_d.input_control_word[ICW_ERR_HI:ICW_ERR_LO] = ERR_BREAK; // RL6
            in_ev = 1'b1;
          end else if (s_q.rxs_late) begin
            s_d.input_control_word[ICW_ERR_HI:ICW_ERR_LO] = ERR_LATE; // RL6
            in_ev = 1'b1;
          end else if (s_q.rxs_perr) begin
            s_d.input_control_word[ICW_ERR_HI:ICW_ERR_LO] = ERR_PARITY; // RL6
            in_ev = 1'b1;
          end
          if (s_q.input_control_word[ICW_ECHO]) begin
            if (!s_d.tx_valid) begin
              s_d.tx_valid = 1'b1; // RL5
              s_d.tx_data = s_q.rxs_data;
              s_d.tx_term = 1'b0;
            end else begin
              s_d.input_control_word[ICW_ECHO_FAIL] = 1'b1; // RL6
              in_ev = 1'b1;
            end
          end
          if (s_q.input_control_word[ICW_MODE] && is_special(s_q.rxs_data)) begin
            s_d.input_control_word[7:0] = s_q.rxs_data; // RL7
            in_ev = 1'b1;
          end
        end else begin
          s_d.input_control_word[7:0] = s_q.rxs_data | (s_q.input_control_word[ICW_MODE] ? MSB_FORCE : 8'h00); // RL1
          in_ev = 1'b1;
        end
        if (in_ev) begin
          s_d.input_control_word[W_DONE] = 1'b1; // RL1 RL4 RL6
          ev_in = 1'b1;
        end
      end
    end
    // Output service, idle while software writes this cycle
    if (s_q.mux_mode && s_q.mux_busy && !s_q.rtc_en && !s_q.output_control_word[W_DONE] && !wr) begin
      case (s_q.output_control_word[14:13])
        OUT_PORTCTL: begin
          // Port control takes effect as soon as it is seen
          s_d.cfg = s_q.output_control_word[11:0];
          out_ev = 1'b1;
        end
        OUT_SINGLE: begin
          if (mismatch) begin
            out_ev = 1'b1; // RL10
          end else if (!s_d.tx_valid) begin
            s_d.tx_valid = 1'b1; // RL2
            s_d.tx_data = s_q.output_control_word[7:0];
            s_d.tx_term = 1'b0;
            out_ev = 1'b1; // RL2
          end
        end
        OUT_AUTO: begin
          if (dev_status != s_q.dev_prev) begin
            s_d.output_control_word[OCW_CHANGED] = 1'b1; // RL11
            out_ev = 1'b1;
          end else if (mismatch) begin
            out_ev = 1'b1; // RL10
          end else if (s_q.output_byte_pointer == s_q.last_output_byte) begin
            out_ev = 1'b1; // RL9
          end else if (!s_d.tx_valid) begin
            s_d.output_byte_pointer = nxt_o; // RL24
            if (s_q.output_control_word[OCW_SPECIAL] && is_special(byte_o)) begin
              s_d.output_control_word[7:0] = byte_o; // RL12
              out_ev = 1'b1;
            end else begin
              s_d.tx_valid = 1'b1; // RL9
              s_d.tx_data = byte_o;
              s_d.tx_term = 1'b0;
              out_ev = (nxt_o == s_q.last_output_byte); // RL9
            end
          end
        end
        default: ;
      endcase
      if (out_ev) begin
        s_d.output_control_word[W_DONE] = 1'b1; // RL2 RL9 RL11
        ev_out = 1'b1;
      end
    end
    s_d.dev_prev = dev_status;
    // Real-time clock runs once started or enabled by P
    if (s_q.mux_busy && (s_q.mux_mode || s_q.rtc_en)) begin
      if (s_q.rtc_cnt == 17'(RTC_TICKS - 1)) begin
        s_d.rtc_cnt = 17'h0_0000;
        s_d.rtc_pend = 1'b1; // RL22
        s_d.mux_done = 1'b1; // RL23
      end else begin
        s_d.rtc_cnt = s_q.rtc_cnt + 17'h0_0001;
      end
    end else begin
      s_d.rtc_cnt = 17'h0_0000;
    end
    // Events last so a set beats a same-cycle clear
    if (ev_in) begin
      s_d.scan_pend = s_d.scan_pend | s_d.in_pend;
      s_d.in_pend = 1'b1;
      s_d.mux_done = 1'b1; // RL23
    end
    if (ev_out) begin
      s_d.scan_pend = s_d.scan_pend | s_d.out_pend;
      s_d.out_pend = 1'b1;
      s_d.mux_done = 1'b1; // RL23
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0; // RL17
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // APB read path, zero wait states
  // ---------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr[7:6] == MEM_PAGE) begin
      prdata = {16'h0000, s_q.mem[paddr[5:2]]};
    end else begin
      case (paddr)
        ADDR_ICW: prdata = {16'h0000, s_q.input_control_word};
        ADDR_OCW: prdata = {16'h0000, s_q.output_control_word};
        ADDR_IBP: prdata = {16'h0000, s_q.input_byte_pointer};
        ADDR_LIB: prdata = {16'h0000, s_q.last_input_byte};
        ADDR_OBP: prdata = {16'h0000, s_q.output_byte_pointer};
        ADDR_LOB: prdata = {16'h0000, s_q.last_output_byte};
        ADDR_STAT: prdata = {16'h0000, stat_w};
        ADDR_STATC: prdata = {16'h0000, stat_w};
        ADDR_CMD: prdata = {28'h000_0000, s_q.rtc_en, s_q.mux_done, s_q.mux_busy, ~s_q.mux_mode};
        ADDR_TERM: prdata = {20'h0_0000, s_q.tto_done, s_q.tto_busy, s_q.tti_done, s_q.tti_busy,
                             s_q.tti_char};
        default: pslverr = psel & penable;
      endcase
    end
  end
  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tx_valid = s_q.tx_valid;
  assign tx_data = s_q.tx_data;
  assign port_cfg = s_q.cfg;
  assign reader_ctrl = s_q.tti_busy; // RL18
  assign term_mode = ~s_q.mux_mode;
  // Terminal flags request service only in terminal mode
  assign intr_req = s_q.mux_done | (~s_q.mux_mode & (s_q.tti_done | s_q.tto_done));

endmodule

// *** verification/mux_channel_properties.sv ***
// Port-level assertions for the multiplexer channel
`timescale 1ns/10ps
module mux_channel_properties
  import mux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [3:0] baud_sel,
  input wire logic [11:0] port_cfg,
  input wire logic reader_ctrl,
  input wire logic term_mode
);
  // ----------
  // Helpers
  // ----------
  logic wacc;
  logic mapped;
  // Write access and decoded address window
  assign wacc = psel && penable && pwrite;
  assign mapped = (paddr <= ADDR_TERM) || (paddr[7:6] == MEM_PAGE);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slverr_map: assert property (psel && penable && paddr[1:0] == 2'b00
    |-> pslverr == !mapped) else $error("slave error disagrees with map");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered character dropped or changed");
  a_reset_cfg: assert property ($rose(presetn)
    |=> port_cfg == (CFG_8N2 | {8'h00, baud_sel}) && term_mode)
    else $error("reset port control wrong");
  a_start_leaves: assert property (wacc && paddr == ADDR_CMD && pwdata[CMD_START]
    && !pwdata[CMD_CLEAR] |=> !term_mode) else $error("start kept terminal mode");
  a_clear_returns: assert property (wacc && paddr == ADDR_CMD && pwdata[CMD_CLEAR]
    && !pwdata[CMD_START] |=> term_mode) else $error("clear did not restore terminal");
  a_cfg_kept: assert property ($rose(term_mode) |-> $stable(port_cfg))
    else $error("port control changed on mode switch");
  a_reader_busy: assert property (wacc && paddr == ADDR_TERM && pwdata[TW_S_IN]
    && term_mode |=> reader_ctrl) else $error("reader control not raised");
  a_reader_drop: assert property (term_mode && reader_ctrl && rx_valid
    |-> ##[1:4] !reader_ctrl) else $error("reader control held after char");
endmodule

bind mux_channel mux_channel_properties mux_channel_properties_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .rx_valid(rx_valid), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .baud_sel(baud_sel), .port_cfg(port_cfg),
  .reader_ctrl(reader_ctrl), .term_mode(term_mode));

// *** verification/port_far.sv ***
// Far-side serial port model: sends received chars, takes sent ones
`timescale 1ns/10ps
module port_far (
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity_err,
  output logic rx_break,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] sent_q[$];
  logic stall;
  // Idle line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_parity_err = 1'b0;
    rx_break = 1'b0;
    tx_ready = 1'b0;
    stall = 1'b0;
  end
  // One received character; afterwards the line no longer shows it
  task automatic send(input logic [7:0] c, input logic pe, input logic bk);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= c;
    rx_parity_err <= pe;
    rx_break <= bk;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~c;
    rx_parity_err <= 1'b0;
    rx_break <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // Takes an offered char; stall holds ready low to test flow control
  always @(posedge pclk) begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready)
      sent_q.push_back(tx_data);
  end
endmodule

// *** verification/mux_channel_tb.sv ***
// Self-checking bench for the multiplexer channel service logic
`timescale 1ns/10ps
module mux_channel_tb;
  import mux_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic rx_valid, rx_parity_err, rx_break, tx_valid, tx_ready;
  logic dev_status, reader_ctrl, term_mode, intr_req;
  logic [3:0] baud_sel;
  logic [11:0] port_cfg;
  int fail_count, num_checks, n, sz;
  // Input mode rows: mode word, char, mask, expected word
  logic [15:0] md [7] = '{16'h4000, 16'h5000, 16'h6000, 16'h7000, 16'h5000, 16'h4000, 16'h4000};
  logic [7:0] ch [7] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h0d, 8'h41, 8'h41};
  logic [15:0] mk [7] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h80ff, 16'h8c00, 16'h8c00};
  logic [15:0] ex [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h800d, 16'h8400, 16'h8c00};

  mux_channel #(.RTC_TICKS(2000)) mux_channel_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_break(rx_break),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .dev_status(dev_status),
    .baud_sel(baud_sel), .port_cfg(port_cfg), .reader_ctrl(reader_ctrl),
    .term_mode(term_mode), .intr_req(intr_req));
  port_far port_far_i (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_parity_err(rx_parity_err), .rx_break(rx_break), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  // ----------
  // Tasks
  // ----------
  // Bus clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // APB transfer; request held until pready seen high, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(rd[15:0] & m, e);
  endtask
  // Bounded read loop until a flag is set, as a service routine would
  task automatic poll(input logic [7:0] a, input int b);
    n = 0;
    do begin
      apb(1'b0, a, 16'h0000);
      n++;
    end while (rd[b] !== 1'b1 && n < 1000);
    chk(16'(rd[b]), 16'h0001);
  endtask

  // ----------
  // Tests
  // ----------
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
  // Main sequence; switch rate is held fixed, status bit is raised once in the output tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    dev_status = 1'b0;
    baud_sel = 4'h5;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(16'(term_mode), 16'h0001);
    chk(16'(port_cfg), 16'h01e5);
    apb(1'b1, ADDR_TERM, 16'h0154);
    poll(ADDR_TERM, 11);
    chk(16'(port_far_i.sent_q[$]), 16'h0054);
    chk(16'(intr_req), 16'h0001);
    apb(1'b1, ADDR_TERM, 16'h0200);
    rchk(ADDR_TERM, 16'h0c00, 16'h0000);
    apb(1'b1, ADDR_TERM, 16'h0400);
    chk(16'(reader_ctrl), 16'h0001);
    port_far_i.send(8'h5a, 1'b0, 1'b0);
    rchk(ADDR_TERM, 16'h03ff, 16'h025a);
    apb(1'b1, ADDR_CMD, 16'h0001);
    rchk(ADDR_TERM, 16'h0f00, 16'h0000);
    rchk(ADDR_CMD, 16'h0003, 16'h0002);
    $display("terminal tests done");
    apb(1'b1, ADDR_ICW, 16'h1000);
    port_far_i.send(8'h41, 1'b0, 1'b0);
    rchk(ADDR_ICW, 16'h80ff, 16'h80c1);
    poll(ADDR_STATC, 13);
    chk(rd[15:0] & 16'h0fe0, 16'h0000);
    apb(1'b0, ADDR_STATC, 16'h0000);
    chk(16'(intr_req), 16'h0000);
    apb(1'b1, ADDR_OCW, 16'h6058);
    poll(ADDR_OCW, 15);
    repeat (4) @(posedge pclk);
    chk(16'(port_far_i.sent_q[$]), 16'h0058);
    // Buffer bytes 2..4; right byte of the last word must survive
    apb(1'b1, 8'h48, 16'h00aa);
    apb(1'b1, ADDR_IBP, 16'h0001);
    apb(1'b1, ADDR_LIB, 16'h0004);
    apb(1'b1, ADDR_ICW, 16'h4000);
    for (int i = 1; i < 4; i++)
      port_far_i.send(8'(i * 17), 1'b0, 1'b0);
    rchk(8'h44, 16'hffff, 16'h1122);
    rchk(8'h48, 16'hffff, 16'h33aa);
    rchk(ADDR_IBP, 16'hffff, 16'h0004);
    rchk(ADDR_ICW, 16'h8000, 16'h8000);
    apb(1'b1, ADDR_ICW, 16'h4000);
    port_far_i.send(8'h44, 1'b0, 1'b0);
    rchk(8'h48, 16'hffff, 16'h3344);
    rchk(ADDR_ICW, 16'h8000, 16'h8000);
    sz = port_far_i.sent_q.size();
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ADDR_IBP, 16'h0007);
      apb(1'b1, ADDR_LIB, 16'h0014);
      apb(1'b1, ADDR_ICW, md[i]);
      port_far_i.send(ch[i], i == 5, i == 6);
      rchk(ADDR_ICW, mk[i], ex[i]);
    end
    chk(16'(port_far_i.sent_q.size() - sz), 16'h0002);
    $display("input tests done");
    // Auto output of bytes 8..10 while the port stalls for a while
    apb(1'b1, 8'h50, 16'h4142);
    apb(1'b1, 8'h54, 16'h4300);
    apb(1'b1, ADDR_OBP, 16'h0007);
    apb(1'b1, ADDR_LOB, 16'h000a);
    sz = port_far_i.sent_q.size();
    port_far_i.stall <= 1'b1;
    apb(1'b1, ADDR_OCW, 16'h2000);
    repeat (20) @(posedge pclk);
    port_far_i.stall <= 1'b0;
    poll(ADDR_OCW, 15);
    repeat (4) @(posedge pclk);
    chk(16'(port_far_i.sent_q.size() - sz), 16'h0003);
    chk({port_far_i.sent_q[$ - 1], port_far_i.sent_q[$]}, 16'h4243);
    rchk(ADDR_OBP, 16'hffff, 16'h000a);
    apb(1'b1, ADDR_OBP, 16'h0007);
    apb(1'b1, ADDR_OCW, 16'h2800);
    rchk(ADDR_OCW, 16'h8000, 16'h8000);
    rchk(ADDR_OBP, 16'hffff, 16'h0007);
    apb(1'b1, 8'h50, 16'h410d);
    apb(1'b1, ADDR_OBP, 16'h0007);
    apb(1'b1, ADDR_OCW, 16'h3000);
    poll(ADDR_OCW, 15);
    rchk(ADDR_OCW, 16'h00ff, 16'h000d);
    rchk(ADDR_OBP, 16'hffff, 16'h0009);
    // Status edge mid-run stops auto output on the loaded char
    apb(1'b1, ADDR_OBP, 16'h0007);
    apb(1'b1, ADDR_OCW, 16'h2000);
    dev_status <= 1'b1;
    poll(ADDR_OCW, 15);
    rchk(ADDR_OCW, 16'h0100, 16'h0100);
    rchk(ADDR_OBP, 16'hffff, 16'h0008);
    apb(1'b1, ADDR_OCW, 16'h6859);
    poll(ADDR_OCW, 15);
    chk(16'(port_far_i.sent_q[$]), 16'h0059);
    // New port control only after output done
    apb(1'b1, ADDR_OCW, 16'h41e7);
    poll(ADDR_OCW, 15);
    chk(16'(port_cfg), 16'h01e7);
    $display("output tests done");
    apb(1'b0, ADDR_STATC, 16'h0000);
    chk(16'(intr_req), 16'h0001);
    apb(1'b1, ADDR_CMD, 16'h0008);
    rchk(ADDR_CMD, 16'h0002, 16'h0000);
    apb(1'b1, ADDR_CMD, 16'h0002);
    chk(16'(term_mode), 16'h0001);
    chk(16'(port_cfg), 16'h01e7);
    apb(1'b1, ADDR_CMD, 16'h0004);
    poll(ADDR_STATC, 15);
    rchk(ADDR_CMD, 16'h0001, 16'h0001);
    apb(1'b0, 8'h30, 16'h0000);
    chk(16'(err), 16'h0001);
    chk(rd[15:0], 16'h0000);
    $display("command tests done");
    tally_and_finish();
  end
endmodule
